// >>> cor_cfg.svh
// register offsets, field positions, reset values and pattern words
`ifndef COR_CFG_SVH
`define COR_CFG_SVH

// register offsets on the serial control port
`define COR_ADDR_TEST 13'h000D
`define COR_ADDR_MODE 13'h0014
`define COR_ADDR_PHASE 13'h0016
`define COR_ADDR_VREF 13'h0018

// reset values
`define COR_RST_TEST 8'h00
`define COR_RST_MODE 8'h00
`define COR_RST_PHASE 8'h00
`define COR_RST_VREF 8'hC0

// test select register fields
`define COR_TEST_SEL_LSB 0
`define COR_TEST_SEL_MSB 2
`define COR_TEST_PN9_RST 4
`define COR_TEST_LONG_PSEUDORANDOM_SEQUENCE_RST 5

// output mode register fields
`define COR_MODE_FMT_LSB 0
`define COR_MODE_FMT_MSB 1
`define COR_MODE_INV 2
`define COR_MODE_DIS 4
`define COR_MODE_DRV_LSB 6
`define COR_MODE_DRV_MSB 7

// output phase and reference fields
`define COR_PHASE_INV 7
`define COR_VREF_LSB 6
`define COR_VREF_MSB 7

// writable bit masks, open bits read zero
`define COR_MASK_TEST 8'h37
`define COR_MASK_MODE 8'hD7
`define COR_MASK_PHASE 8'h80
`define COR_MASK_VREF 8'hC0

// fixed pattern words, offset binary
`define COR_WORD_MID 12'h800
`define COR_WORD_PFS 12'hFFF
`define COR_WORD_NFS 12'h000
`define COR_WORD_CHK 12'hAAA

// sequence seeds
`define COR_SEED_LONG 23'h7FFFFF
`define COR_SEED_SHORT 9'h1FF

// serial frame length: 16 instruction bits then 8 data bits
`define COR_SPI_INSTR_BITS 5'h10
`define COR_SPI_FRAME_BITS 5'h18

`endif

// >>> cor_output_regs.sv
// output configuration registers and parallel output data path
`timescale 1ns/100ps
`include "cor_cfg.svh"

// What this block does
// - test codes 0-3: normal, midscale, plus, minus
// - codes 4-7: checker, long, short PN, toggle
// - disable bit set turns data drivers off
// - drivers on only with enable pin high
// - phase bit 7 inverts output clock
module cor_output_regs (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // serial control pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdio_i,
    output logic spi_sdio_o,
    output logic spi_sdio_oe_o,
    // converter core result, same clock
    input wire logic [11:0] conv_data_i,
    // external output enable pin, drivers on while high
    input wire logic output_enable_pin_n_i,
    // parallel outputs
    output logic [11:0] data_o,
    output logic data_oe_o,
    output logic data_output_clock_o,
    // analog controls
    output logic [1:0] drive_strength_o,
    output logic [1:0] ref_level_sel_o
);
    import cor_pkg::*;

    // ------------------------------------------------------------
    // serial port
    // ------------------------------------------------------------
    cor_reg_req_s req;
    logic [7:0] rdata;

    cor_spi_slave u_spi (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .spi_sclk_i(spi_sclk_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_sdio_i(spi_sdio_i),
        .spi_sdio_o(spi_sdio_o),
        .spi_sdio_oe_o(spi_sdio_oe_o),
        .req_o(req),
        .rdata_i(rdata)
    );

    // ------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------
    logic [7:0] output_test_pattern_select;
    logic [7:0] output_driver_and_format;
    logic [7:0] output_clock_polarity;
    logic [7:0] reference_level_select;

    // open bits are masked so they always read zero
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            output_test_pattern_select <= `COR_RST_TEST;
            output_driver_and_format <= `COR_RST_MODE;
            output_clock_polarity <= `COR_RST_PHASE;
            reference_level_select <= `COR_RST_VREF;
        end else if (req.wr) begin
            case (req.addr)
                `COR_ADDR_TEST: begin
                    output_test_pattern_select <= req.wdata & `COR_MASK_TEST;
                end
                `COR_ADDR_MODE: begin
                    output_driver_and_format <= req.wdata & `COR_MASK_MODE;
                end
                `COR_ADDR_PHASE: begin
                    output_clock_polarity <= req.wdata & `COR_MASK_PHASE;
                end
                `COR_ADDR_VREF: begin
                    reference_level_select <= req.wdata & `COR_MASK_VREF;
                end
                default: begin
                end
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        case (req.addr)
            `COR_ADDR_TEST: rdata = output_test_pattern_select;
            `COR_ADDR_MODE: rdata = output_driver_and_format;
            `COR_ADDR_PHASE: rdata = output_clock_polarity;
            `COR_ADDR_VREF: rdata = reference_level_select;
            default: rdata = 8'h00;
        endcase
    end

    // field extraction
    cor_test_e test_sel;
    cor_fmt_e fmt_sel;
    logic data_inv;
    logic out_dis;
    logic clk_inv;
    assign test_sel = cor_test_e'(output_test_pattern_select[
        `COR_TEST_SEL_MSB:`COR_TEST_SEL_LSB]);
    assign fmt_sel = cor_fmt_e'(output_driver_and_format[
        `COR_MODE_FMT_MSB:`COR_MODE_FMT_LSB]);
    assign data_inv = output_driver_and_format[`COR_MODE_INV];
    assign out_dis = output_driver_and_format[`COR_MODE_DIS];
    assign clk_inv = output_clock_polarity[`COR_PHASE_INV];
    assign drive_strength_o = output_driver_and_format[
        `COR_MODE_DRV_MSB:`COR_MODE_DRV_LSB];
    assign ref_level_sel_o = reference_level_select[
        `COR_VREF_MSB:`COR_VREF_LSB];

    // ------------------------------------------------------------
    // output enable pin
    // ------------------------------------------------------------
    logic [1:0] oe_pin_sync;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            oe_pin_sync <= 2'h3;
        end else begin
            oe_pin_sync <= {oe_pin_sync[0], output_enable_pin_n_i};
        end
    end

    // drivers on only when the bit is clear and the pin is high
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= !out_dis && oe_pin_sync[1];
        end
    end

    // ------------------------------------------------------------
    // word timing and output clock
    // ------------------------------------------------------------
    // one output word per two ref clocks so the clock can be a flop
    logic word_phase;
    logic word_step;
    assign word_step = !word_phase;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_phase <= 1'b0;
        end else begin
            word_phase <= !word_phase;
        end
    end

    // clock rises mid-word when normal; inversion swaps the edge
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_output_clock_o <= 1'b0;
        end else begin
            data_output_clock_o <= word_phase ^ clk_inv;
        end
    end

    // ------------------------------------------------------------
    // pattern generators
    // ------------------------------------------------------------
    logic [22:0] long_pseudorandom_sequence;
    logic [8:0] short_pseudorandom_sequence;
    logic toggle;

    // long sequence x^23 + x^18 + 1; reset bit holds it at seed
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            long_pseudorandom_sequence <= `COR_SEED_LONG;
        end else if (output_test_pattern_select[`COR_TEST_LONG_PSEUDORANDOM_SEQUENCE_RST]) begin
            long_pseudorandom_sequence <= `COR_SEED_LONG;
        end else if (word_step) begin
            long_pseudorandom_sequence <= {long_pseudorandom_sequence[21:0],
                long_pseudorandom_sequence[22] ^
                long_pseudorandom_sequence[17]};
        end
    end

    // short sequence x^9 + x^5 + 1
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            short_pseudorandom_sequence <= `COR_SEED_SHORT;
        end else if (output_test_pattern_select[`COR_TEST_PN9_RST]) begin
            short_pseudorandom_sequence <= `COR_SEED_SHORT;
        end else if (word_step) begin
            short_pseudorandom_sequence <= {
                short_pseudorandom_sequence[7:0],
                short_pseudorandom_sequence[8] ^
                short_pseudorandom_sequence[4]};
        end
    end

    // alternation flag shared by checkerboard and word toggle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            toggle <= 1'b0;
        end else if (word_step) begin
            toggle <= !toggle;
        end
    end

    // ------------------------------------------------------------
    // source select and formatting
    // ------------------------------------------------------------
    logic [11:0] src_word;
    logic [11:0] fmt_word;

    // patterns are offset-binary words and go through the formatter
    always_comb begin
        case (test_sel)
            COR_TEST_OFF: src_word = conv_data_i;
            COR_TEST_MID: src_word = `COR_WORD_MID;
            COR_TEST_PFS: src_word = `COR_WORD_PFS;
            COR_TEST_NFS: src_word = `COR_WORD_NFS;
            COR_TEST_CHK: begin
                src_word = toggle ? ~`COR_WORD_CHK : `COR_WORD_CHK;
            end
            COR_TEST_LONG: begin
                src_word = long_pseudorandom_sequence[11:0];
            end
            COR_TEST_SHORT: begin
                src_word = {3'h0, short_pseudorandom_sequence};
            end
            COR_TEST_TOGGLE: begin
                src_word = toggle ? `COR_WORD_PFS : `COR_WORD_NFS;
            end
            default: src_word = conv_data_i;
        endcase
    end

    // code 11 is unused and falls back to offset binary
    always_comb begin
        case (fmt_sel)
            COR_FMT_TWOS: fmt_word = {~src_word[11], src_word[10:0]};
            COR_FMT_GRAY: fmt_word = src_word ^ (src_word >> 1);
            default: fmt_word = src_word;
        endcase
    end

    // data launches at word start; invert applies last
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_o <= 12'h000;
        end else if (word_step) begin
            data_o <= data_inv ? ~fmt_word : fmt_word;
        end
    end

endmodule

// >>> cor_output_regs_assertions.sv
// port checker for the output configuration block
`timescale 1ns/100ps

module cor_output_regs_checker (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // pins driven from outside
    input wire logic spi_cs_n_i,
    input wire logic output_enable_pin_n_i,
    // watched outputs
    input wire logic spi_sdio_oe_o,
    input wire logic [11:0] data_o,
    input wire logic data_oe_o,
    input wire logic data_output_clock_o,
    input wire logic [1:0] drive_strength_o,
    input wire logic [1:0] ref_level_sel_o
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    // two cycles out of reset before the toggle is judged
    sequence s_run;
        !rst_i ##1 !rst_i;
    endsequence
    // pin low long enough to pass its synchroniser
    sequence s_pin_low;
        !output_enable_pin_n_i [*5];
    endsequence

    property p_word_hold;
        $changed(data_o) |=> $stable(data_o);
    endproperty
    // a polarity change may hold the clock for one cycle, never two
    property p_clk_toggle;
        s_run ##0 $stable(data_output_clock_o) |=>
            $changed(data_output_clock_o);
    endproperty
    property p_pin_off;
        s_pin_low |-> !data_oe_o;
    endproperty
    property p_cfg_frame;
        $changed(drive_strength_o) || $changed(ref_level_sel_o)
            |-> !$past(spi_cs_n_i, 5);
    endproperty
    property p_sdio_idle;
        spi_cs_n_i [*5] |-> !spi_sdio_oe_o;
    endproperty
    property p_reset_out;
        $fell(rst_i) |-> ref_level_sel_o == 2'h3 && drive_strength_o == 2'h0;
    endproperty

    a_word_hold:
    assert property (p_word_hold) else $error("word held one cycle only");
    a_clk_toggle:
    assert property (p_clk_toggle) else $error("output clock stalled");
    a_pin_off:
    assert property (p_pin_off) else $error("drivers on with pin low");
    a_cfg_frame:
    assert property (p_cfg_frame) else $error("config changed without frame");
    a_sdio_idle:
    assert property (p_sdio_idle) else $error("sdio driven while idle");
    a_reset_out:
    assert property (p_reset_out) else $error("bad control reset value");
endmodule

bind cor_output_regs cor_output_regs_checker u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .spi_cs_n_i(spi_cs_n_i),
    .output_enable_pin_n_i(output_enable_pin_n_i),
    .spi_sdio_oe_o(spi_sdio_oe_o), .data_o(data_o), .data_oe_o(data_oe_o),
    .data_output_clock_o(data_output_clock_o),
    .drive_strength_o(drive_strength_o), .ref_level_sel_o(ref_level_sel_o)
);

// >>> cor_pkg.sv
// types shared by the output configuration block
package cor_pkg;

    // global output test selection codes
    typedef enum logic [2:0] {
        COR_TEST_OFF = 3'h0,
        COR_TEST_MID = 3'h1,
        COR_TEST_PFS = 3'h2,
        COR_TEST_NFS = 3'h3,
        COR_TEST_CHK = 3'h4,
        COR_TEST_LONG = 3'h5,
        COR_TEST_SHORT = 3'h6,
        COR_TEST_TOGGLE = 3'h7
    } cor_test_e;

    // output data format codes
    typedef enum logic [1:0] {
        COR_FMT_OFFSET = 2'h0,
        COR_FMT_TWOS = 2'h1,
        COR_FMT_GRAY = 2'h2
    } cor_fmt_e;

    // serial port frame states
    typedef enum logic [2:0] {
        COR_SPI_IDLE = 3'h1,
        COR_SPI_INSTR = 3'h2,
        COR_SPI_DATA = 3'h4
    } cor_spi_state_e;

    // register access from the serial port to the bank
    typedef struct packed {
        logic wr;
        logic [12:0] addr;
        logic [7:0] wdata;
    } cor_reg_req_s;

endpackage

// >>> cor_rx_model.sv
// receiving logic model that captures output words on the active clock edge
`timescale 1ns/100ps

module cor_rx_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // bench controls
    input wire logic want_i,
    input wire logic pol_i,
    // converter side
    input wire logic [11:0] data_i,
    input wire logic data_oe_i,
    input wire logic data_output_clock_i,
    output logic output_enable_pin_n_o,
    // captured word and running count
    output logic [11:0] word_o,
    output int count_o
);
    logic last_q;

    // pin held high whenever data is wanted
    assign output_enable_pin_n_o = want_i;

    // capture mid-word; a floating bus is never taken as data
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_q <= 1'b0;
            word_o <= 12'h000;
            count_o <= 0;
        end else begin
            last_q <= data_output_clock_i;
            if (data_oe_i && data_output_clock_i != pol_i &&
                last_q == pol_i) begin
                word_o <= data_i;
                count_o <= count_o + 1;
            end
        end
    end
endmodule

// >>> cor_spi_slave.sv
// serial control port slave: 16-bit instruction then one data byte
`timescale 1ns/100ps
`include "cor_cfg.svh"

module cor_spi_slave (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // serial pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdio_i,
    output logic spi_sdio_o,
    output logic spi_sdio_oe_o,
    // register bank side
    output cor_pkg::cor_reg_req_s req_o,
    input wire logic [7:0] rdata_i
);
    import cor_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] sdio_sync;
    logic sclk_q;

    // two stages each; only stage 1 feeds the logic
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            sdio_sync <= 2'h0;
            sclk_q <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], spi_sclk_i};
            cs_sync <= {cs_sync[0], spi_cs_n_i};
            sdio_sync <= {sdio_sync[0], spi_sdio_i};
            sclk_q <= sclk_sync[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_n;
    assign sclk_rise = sclk_sync[1] & ~sclk_q;
    assign sclk_fall = ~sclk_sync[1] & sclk_q;
    assign cs_n = cs_sync[1];

    // ------------------------------------------------------------
    // frame sequencing
    // ------------------------------------------------------------
    cor_spi_state_e state;
    logic [4:0] bit_cnt;
    logic [15:0] instr;
    logic [7:0] din;
    logic [7:0] dout;
    logic is_read;

    // sclk must be slow against ref_clk: edges are found by sampling
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= COR_SPI_IDLE;
            bit_cnt <= 5'h00;
            instr <= 16'h0000;
            din <= 8'h00;
        end else begin
            case (state)
                COR_SPI_IDLE: begin
                    bit_cnt <= 5'h00;
                    if (!cs_n) begin
                        state <= COR_SPI_INSTR;
                    end
                end
                COR_SPI_INSTR: begin
                    if (cs_n) begin
                        state <= COR_SPI_IDLE;
                    end else if (sclk_rise) begin
                        instr <= {instr[14:0], sdio_sync[1]};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == `COR_SPI_INSTR_BITS - 5'h01) begin
                            state <= COR_SPI_DATA;
                        end
                    end
                end
                COR_SPI_DATA: begin
                    if (cs_n || bit_cnt == `COR_SPI_FRAME_BITS) begin
                        state <= COR_SPI_IDLE;
                    end else if (sclk_rise) begin
                        din <= {din[6:0], sdio_sync[1]};
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
                default: begin
                    state <= COR_SPI_IDLE;
                end
            endcase
        end
    end

    assign is_read = instr[15];

    // read data: load at end of instruction, shift on falling sclk
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout <= 8'h00;
            spi_sdio_o <= 1'b0;
            spi_sdio_oe_o <= 1'b0;
        end else if (state != COR_SPI_DATA || !is_read || cs_n) begin
            dout <= rdata_i;
            spi_sdio_o <= 1'b0;
            spi_sdio_oe_o <= 1'b0;
        end else if (sclk_fall) begin
            spi_sdio_o <= dout[7];
            spi_sdio_oe_o <= 1'b1;
            dout <= {dout[6:0], 1'b0};
        end else if (!spi_sdio_oe_o) begin
            // the address register lags the last instruction bit by a clock
            dout <= rdata_i;
        end
    end

    // one-cycle write strobe once the eighth data bit is in
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_o <= '0;
        end else begin
            req_o.addr <= instr[12:0];
            req_o.wdata <= din;
            // raised a cycle after the last rise, when din holds all 8 bits
            req_o.wr <= (state == COR_SPI_DATA) && !is_read && !cs_n &&
                        (bit_cnt == `COR_SPI_FRAME_BITS);
        end
    end

endmodule

// >>> testbench.sv
// self-checking bench for the output configuration block
`timescale 1ns/100ps
`include "cor_cfg.svh"

module testbench;
    import cor_pkg::*;

    // ----
    // stimulus and observed signals
    // ----
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sclk = 1'b0;
    logic cs_n = 1'b1;
    logic sd_tb = 1'b0;
    logic want = 1'b1;
    logic pol = 1'b0;
    logic [11:0] conv = 12'h000;
    logic sd_o, sd_oe, oe, oclk, pin_n;
    logic [11:0] data, word;
    logic [1:0] drive, refsel;
    int count;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'hE460A3C6;
    logic [7:0] rd;
    logic [12:0] adr [4] = '{`COR_ADDR_TEST, `COR_ADDR_MODE,
        `COR_ADDR_PHASE, `COR_ADDR_VREF};
    logic [7:0] msk [4] = '{`COR_MASK_TEST, `COR_MASK_MODE,
        `COR_MASK_PHASE, `COR_MASK_VREF};
    logic [7:0] rstv [4] = '{8'h00, 8'h00, 8'h00, 8'hC0};
    logic [7:0] fm [7] = '{8'h00, 8'h41, 8'h82, 8'hC3, 8'h04, 8'h45, 8'h86};
    // shared data line: the block wins while it drives
    wire sd_w = sd_oe ? sd_o : sd_tb;

    always #25 ref_clk_i = ~ref_clk_i;

    cor_output_regs uut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_sdio_i(sd_w), .spi_sdio_o(sd_o),
        .spi_sdio_oe_o(sd_oe), .conv_data_i(conv),
        .output_enable_pin_n_i(pin_n), .data_o(data), .data_oe_o(oe),
        .data_output_clock_o(oclk), .drive_strength_o(drive),
        .ref_level_sel_o(refsel)
    );
    cor_rx_model rx (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .want_i(want), .pol_i(pol),
        .data_i(data), .data_oe_i(oe), .data_output_clock_i(oclk),
        .output_enable_pin_n_o(pin_n), .word_o(word), .count_o(count)
    );

    // ----
    // helpers and reference model
    // ----
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // format then invert, invert last
    function automatic logic [11:0] fmt(input logic [11:0] w,
                                        input logic [7:0] m);
        logic [11:0] r;
        case (m[1:0])
            2'h1: r = {~w[11], w[10:0]};
            2'h2: r = w ^ (w >> 1);
            default: r = w;
        endcase
        return m[2] ? ~r : r;
    endfunction

    // expected word after w for pattern c; v fills bits not predictable
    function automatic logic [11:0] pat(input int c, input logic [11:0] w,
                                        input logic [11:0] v);
        case (c)
            1: return 12'h800;
            2: return 12'hFFF;
            3: return 12'h000;
            4: return (w == 12'hAAA) ? 12'h555 : 12'hAAA;
            5: return {w[10:0], v[0]};
            6: return {3'h0, v[8:0]};
            default: return (w == 12'hFFF) ? 12'h000 : 12'hFFF;
        endcase
    endfunction

    task automatic results();
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // one frame, msb first; sclk kept well under an eighth of the clock
    task automatic spi(input logic [15:0] ins, input logic [7:0] wd,
                       output logic [7:0] rdat);
        logic [23:0] sh;
        sh = {ins, wd};
        rdat = 8'h00;
        cs_n = 1'b0;
        cyc(6);
        for (int i = 23; i >= 0; i--) begin
            sclk = 1'b0;
            sd_tb = (ins[15] && i < 8) ? ~sd_tb : sh[i];
            cyc(6);
            rdat = {rdat[6:0], sd_w};
            sclk = 1'b1;
            cyc(6);
        end
        sclk = 1'b0;
        cyc(6);
        cs_n = 1'b1;
        cyc(6);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi({3'h0, a}, d, x);
    endtask

    task automatic rdr(input logic [12:0] a, output logic [7:0] d);
        spi({3'h4, a}, 8'h00, d);
    endtask

    // next captured word, bounded wait
    task automatic nxt(output logic [11:0] w);
        int last;
        last = count;
        for (int i = 0; i < 40 && count == last; i++) cyc(1);
        w = word;
        if (count == last) begin
            num_errors++;
            results();
        end
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        logic [11:0] w, v;
        logic [31:0] r;
        logic [7:0] m;
        cyc(12);
        rst_i = 1'b0;
        cyc(4);
        // reset values, then random write and read back
        for (int i = 0; i < 4; i++) begin
            rdr(adr[i], rd);
            chk("reset value", {4'h0, rstv[i]}, {4'h0, rd});
            r = rnd();
            m = r[7:0];
            wr(adr[i], m);
            rdr(adr[i], rd);
            chk("read back", {4'h0, m & msk[i]}, {4'h0, rd});
        end
        chk("ref select", {10'h0, m[7:6]}, {10'h0, refsel});
        wr(13'h0015, 8'hFF);
        rdr(13'h0015, rd);
        chk("unmapped", 12'h000, {4'h0, rd});
        for (int i = 0; i < 3; i++) wr(adr[i], 8'h00);
        // driver disable bit and enable pin
        wr(`COR_ADDR_MODE, 8'h10);
        chk("drivers off", 12'h000, {11'h0, oe});
        wr(`COR_ADDR_MODE, 8'h00);
        chk("drivers on", 12'h001, {11'h0, oe});
        want = 1'b0;
        cyc(8);
        chk("pin low", 12'h000, {11'h0, oe});
        want = 1'b1;
        cyc(8);
        // normal data in every format, random input word
        for (int i = 0; i < 7; i++) begin
            r = rnd();
            conv = r[11:0];
            wr(`COR_ADDR_MODE, fm[i]);
            chk("drive", {10'h0, fm[i][7:6]}, {10'h0, drive});
            nxt(w);
            nxt(w);
            chk("format", fmt(conv, fm[i]), w);
        end
        wr(`COR_ADDR_MODE, 8'h00);
        // test codes 1-7, both clock polarities
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            wr(`COR_ADDR_PHASE, {p[0], 7'h00});
            for (int c = 1; c < 8; c++) begin
                wr(`COR_ADDR_TEST, {5'h0, c[2:0]});
                nxt(w);
                nxt(w);
                nxt(v);
                chk("pattern", pat(c, w, v), v);
            end
            for (int k = 0; k < 24; k++) begin
                v = data;
                cyc(1);
                if (data !== v) begin
                    chk("clock level", {11'h0, pol}, {11'h0, oclk});
                end
            end
        end
        // sequences held at their seeds
        wr(`COR_ADDR_TEST, 8'h25);
        nxt(w);
        nxt(w);
        chk("long seed", 12'hFFF, w);
        wr(`COR_ADDR_TEST, 8'h16);
        nxt(w);
        nxt(w);
        chk("short seed", 12'h1FF, w);
        results();
    end
endmodule
